// >>> rtl/cantxs_top.sv
// Purpose: transmit mailbox 0/1 status flags with Avalon-MM slave and interrupt
// Assumes: mailbox events are one-cycle pulses synchronous to clk
// Notes:   one wait state on every access; status bits 6:4 and 31:12 read zero
// Overview of operation
// - mailbox 1 arbitration-lost set on loss; cleared by write one or next start
// - mailbox 1 success shows last result; write one clears it
// - mailbox 1 complete set when transmit or abort ends; cleared by write or new request
// - clearing mailbox 1 complete also clears its success, arbitration-lost and error
// - writing one to mailbox 0 cancel aborts; self-clears on removal; zero ignored
// - mailbox 0 cancel write ignored while mailbox 0 is free
// - status bits six to four are reserved, ignore writes, read zero
// - mailbox 0 error set on error; cleared at next start or by write
// - mailbox 0 arbitration-lost set on loss; cleared by write one or next start
// - mailbox 0 success shows last result; write one clears it
// - mailbox 0 complete set at end of request; cleared by write or new request
// - clearing mailbox 0 complete also clears its success, arbitration-lost and error
// - mailbox 1 error set on error; cleared by write one or next start
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cantxs_top (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // avalon-mm slave
  input  wire logic [3:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // mailbox events
  input  wire cantxs_pkg::cantxs_mbox_ev_s mbox0_ev,
  input  wire cantxs_pkg::cantxs_mbox_ev_s mbox1_ev,
  // mailbox 0 abort request to the mailbox state machine
  output logic                             mbox0_cancel_request,
  // interrupt
  output logic                             irq
);

  typedef struct packed {
    cantxs_pkg::cantxs_bus_e bus;
    logic [31:0]             rdata;
    logic [3:0]              irq_sts;
    logic [3:0]              irq_mask;
  } cantxs_state_s;

  cantxs_state_s             state_q;
  cantxs_state_s             state_d;
  cantxs_pkg::cantxs_flags_s flags0;
  cantxs_pkg::cantxs_flags_s flags1;
  logic                      cancel0;
  logic                      wr_stb;
  logic                      rd_stb;
  logic [31:0]               wmask;
  logic [31:0]               w1;
  logic [31:0]               status_word;
  logic [3:0]                irq_ev;

  // accept in ST_ACK so each access takes exactly one wait state
  assign wr_stb = avs_write && (state_q.bus == cantxs_pkg::ST_ACK);
  // read data is captured on the first edge so it already stands at the accept edge
  assign rd_stb = avs_read && (state_q.bus == cantxs_pkg::ST_IDLE);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  assign w1 = (wr_stb && (avs_address == cantxs_pkg::ADDR_STATUS)) ?
              (avs_writedata & wmask) : 32'h0000_0000;

  // mailbox 0 error clears on written one, the usual w1c sense
  cantxs_mbox_flags u_mbox0 (
    .clk          (clk),
    .reset_n      (reset_n),
    .ev           (mbox0_ev),
    .clr_complete (w1[cantxs_pkg::B0_COMPLETE]),
    .clr_success  (w1[cantxs_pkg::B0_SUCCESS]),
    .clr_arb_lost (w1[cantxs_pkg::B0_ARB_LOST]),
    .clr_error    (w1[cantxs_pkg::B0_ERROR]),
    .flags        (flags0)
  );

  cantxs_mbox_flags u_mbox1 (
    .clk          (clk),
    .reset_n      (reset_n),
    .ev           (mbox1_ev),
    .clr_complete (w1[cantxs_pkg::B1_COMPLETE]),
    .clr_success  (w1[cantxs_pkg::B1_SUCCESS]),
    .clr_arb_lost (w1[cantxs_pkg::B1_ARB_LOST]),
    .clr_error    (w1[cantxs_pkg::B1_ERROR]),
    .flags        (flags1)
  );

  cantxs_cancel u_cancel0 (
    .clk     (clk),
    .reset_n (reset_n),
    .set_req (w1[cantxs_pkg::B0_CANCEL]),
    .pending (mbox0_ev.pending),
    .removed (mbox0_ev.removed),
    .cancel  (cancel0)
  );

  always_comb
  begin
    status_word = cantxs_pkg::STATUS_RESET;
    status_word[cantxs_pkg::B0_COMPLETE] = flags0.complete;
    status_word[cantxs_pkg::B0_SUCCESS]  = flags0.success;
    status_word[cantxs_pkg::B0_ARB_LOST] = flags0.arb_lost;
    status_word[cantxs_pkg::B0_ERROR]    = flags0.error;
    status_word[cantxs_pkg::B0_CANCEL]   = cancel0;
    status_word[cantxs_pkg::B1_COMPLETE] = flags1.complete;
    status_word[cantxs_pkg::B1_SUCCESS]  = flags1.success;
    status_word[cantxs_pkg::B1_ARB_LOST] = flags1.arb_lost;
    status_word[cantxs_pkg::B1_ERROR]    = flags1.error;
  end

  // interrupt events: bit0 mbox0 done, bit1 mbox0 error, bit2 mbox1 done, bit3 mbox1 error
  assign irq_ev = {mbox1_ev.error, mbox1_ev.done, mbox0_ev.error, mbox0_ev.done};

  always_comb
  begin
    state_d = state_q;
    case (state_q.bus)
      cantxs_pkg::ST_IDLE:
      begin
        if (avs_read || avs_write)
          state_d.bus = cantxs_pkg::ST_ACK;
      end
      cantxs_pkg::ST_ACK:
      begin
        state_d.bus = cantxs_pkg::ST_IDLE;
      end
      default:
      begin
        state_d.bus = cantxs_pkg::ST_IDLE;
      end
    endcase
    if (rd_stb)
    begin
      if (avs_address == cantxs_pkg::ADDR_STATUS)
        state_d.rdata = status_word;
      else if (avs_address == cantxs_pkg::ADDR_IRQ_STS)
        state_d.rdata = {28'h0000000, state_q.irq_sts};
      else if (avs_address == cantxs_pkg::ADDR_IRQ_MASK)
        state_d.rdata = {28'h0000000, state_q.irq_mask};
      else
        state_d.rdata = cantxs_pkg::READ_UNMAPPED;
    end
    if (wr_stb && (avs_address == cantxs_pkg::ADDR_IRQ_STS) && avs_byteenable[0])
      state_d.irq_sts = state_q.irq_sts & ~avs_writedata[3:0];
    if (wr_stb && (avs_address == cantxs_pkg::ADDR_IRQ_MASK) && avs_byteenable[0])
      state_d.irq_mask = avs_writedata[3:0];
    // new events win over a same-cycle clear
    state_d.irq_sts = state_d.irq_sts | irq_ev;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q.bus      <= cantxs_pkg::ST_IDLE;
      state_q.rdata    <= cantxs_pkg::READ_UNMAPPED;
      state_q.irq_sts  <= cantxs_pkg::IRQ_RESET;
      state_q.irq_mask <= cantxs_pkg::IRQ_RESET;
    end
    else
      state_q <= state_d;
  end

  // readdata is a registered copy taken during the wait state, valid while waitrequest is low
  always_comb
  begin
    avs_waitrequest = (avs_read || avs_write) && (state_q.bus != cantxs_pkg::ST_ACK);
  end

  assign avs_readdata         = state_q.rdata;
  assign mbox0_cancel_request = cancel0;
  assign irq                  = |(state_q.irq_sts & state_q.irq_mask);

  a_resv_zero: assert property (@(posedge clk) disable iff (!reset_n)
    rd_stb && (avs_address == cantxs_pkg::ADDR_STATUS) |=> avs_readdata[6:4] == 3'h0)
    else $error("reserved status bits read nonzero");

  a_wait_one: assert property (@(posedge clk) disable iff (!reset_n)
    ($rose(avs_read) && $past(state_q.bus) == cantxs_pkg::ST_IDLE) |-> avs_waitrequest ##1
      !avs_waitrequest)
    else $error("read not answered after one wait state");

  a_m1_clr: assert property (@(posedge clk) disable iff (!reset_n)
    (w1[cantxs_pkg::B1_COMPLETE] && !mbox1_ev.done && !mbox1_ev.error && !mbox1_ev.arb_lost)
      |=> status_word[11:8] == 4'h0)
    else $error("mailbox 1 completion clear left flags set");

  a_m1_alost: assert property (@(posedge clk) disable iff (!reset_n)
    mbox1_ev.arb_lost |=> status_word[cantxs_pkg::B1_ARB_LOST])
    else $error("mailbox 1 arbitration lost not set");

  a_m0_err: assert property (@(posedge clk) disable iff (!reset_n)
    mbox0_ev.error |=> status_word[cantxs_pkg::B0_ERROR] && state_q.irq_sts[1])
    else $error("mailbox 0 error not flagged");

  a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
    irq == |(state_q.irq_sts & state_q.irq_mask))
    else $error("irq disagrees with status and mask");

  c_m0_done: cover property (@(posedge clk) disable iff (!reset_n)
    mbox0_ev.done && mbox0_ev.ok);
  c_m1_fail: cover property (@(posedge clk) disable iff (!reset_n)
    mbox1_ev.done && !mbox1_ev.ok);
  c_cancel: cover property (@(posedge clk) disable iff (!reset_n)
    cancel0 ##[1:20] mbox0_ev.removed);
  c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));

endmodule : cantxs_top
`default_nettype wire

// >>> include/cantxs_pkg.sv
// Purpose: shared constants and types for the transmit mailbox status flags
// Assumes: 32-bit Avalon-MM register bus, word-aligned byte addresses
// Notes:   bit positions follow the transmit status register layout
package cantxs_pkg;

  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

  localparam int B0_COMPLETE = 0;
  localparam int B0_SUCCESS = 1;
  localparam int B0_ARB_LOST = 2;
  localparam int B0_ERROR = 3;
  localparam int B0_CANCEL = 7;
  localparam int B1_COMPLETE = 8;
  localparam int B1_SUCCESS = 9;
  localparam int B1_ARB_LOST = 10;
  localparam int B1_ERROR = 11;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // per-mailbox event inputs from the mailbox state machine
  typedef struct packed {
    logic start;
    logic new_request;
    logic done;
    logic ok;
    logic arb_lost;
    logic error;
    logic pending;
    logic removed;
  } cantxs_mbox_ev_s;

  // per-mailbox flag state
  typedef struct packed {
    logic complete;
    logic success;
    logic arb_lost;
    logic error;
  } cantxs_flags_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } cantxs_bus_e;

endpackage : cantxs_pkg

// >>> rtl/cantxs_mbox_flags.sv
// Purpose: flag set for one transmit mailbox
// Assumes: events are single-cycle pulses from the mailbox state machine
// Notes:   hardware sets win over a same-cycle software clear
`timescale 1ns/1ns
`default_nettype none
module cantxs_mbox_flags (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // events
  input  wire cantxs_pkg::cantxs_mbox_ev_s ev,
  // software write-one-to-clear
  input  wire logic                      clr_complete,
  input  wire logic                      clr_success,
  input  wire logic                      clr_arb_lost,
  input  wire logic                      clr_error,
  // flags
  output cantxs_pkg::cantxs_flags_s      flags
);

  cantxs_pkg::cantxs_flags_s state_q;
  cantxs_pkg::cantxs_flags_s state_d;
  logic                      clear_all;

  always_comb
  begin
    state_d = state_q;
    // a completion clear drags the other flags with it
    clear_all = clr_complete || ev.new_request;
    if (clear_all)
    begin
      state_d.complete = 1'b0;
      state_d.success  = 1'b0;
      state_d.arb_lost = 1'b0;
      state_d.error    = 1'b0;
    end
    if (clr_success)
      state_d.success = 1'b0;
    if (clr_arb_lost || ev.start)
      state_d.arb_lost = 1'b0;
    if (clr_error || ev.start)
      state_d.error = 1'b0;
    if (ev.done)
    begin
      state_d.complete = 1'b1;
      state_d.success  = ev.ok;
    end
    if (ev.arb_lost)
      state_d.arb_lost = 1'b1;
    if (ev.error)
      state_d.error = 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign flags = state_q;

  a_done_sets: assert property (@(posedge clk) disable iff (!reset_n)
    ev.done |=> flags.complete && (flags.success == $past(ev.ok)))
    else $error("completion did not set complete and success");

  a_clear_all: assert property (@(posedge clk) disable iff (!reset_n)
    (clr_complete && !ev.done && !ev.arb_lost && !ev.error) |=>
      !flags.complete && !flags.success && !flags.arb_lost && !flags.error)
    else $error("completion clear left other flags set");

  a_start_clrs: assert property (@(posedge clk) disable iff (!reset_n)
    (ev.start && !ev.arb_lost && !ev.error) |=> !flags.arb_lost && !flags.error)
    else $error("start of transmission did not clear error flags");

endmodule : cantxs_mbox_flags
`default_nettype wire

// >>> rtl/cantxs_cancel.sv
// Purpose: mailbox 0 cancel request bit
// Assumes: removed pulses when the pending message leaves the mailbox
// Notes:   a write while the mailbox is free is dropped
`timescale 1ns/1ns
`default_nettype none
module cantxs_cancel (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // control
  input  wire logic set_req,
  input  wire logic pending,
  input  wire logic removed,
  // state
  output logic      cancel
);

  logic cancel_q;
  logic cancel_d;

  always_comb
  begin
    cancel_d = cancel_q;
    if (removed)
      cancel_d = 1'b0;
    else if (set_req && pending)
      cancel_d = 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cancel_q <= 1'b0;
    else
      cancel_q <= cancel_d;
  end

  assign cancel = cancel_q;

  a_free_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    (set_req && !pending && !cancel) |=> !cancel)
    else $error("cancel set while mailbox free");

  a_removed_clr: assert property (@(posedge clk) disable iff (!reset_n)
    removed |=> !cancel)
    else $error("cancel not cleared on removal");

endmodule : cantxs_cancel
`default_nettype wire

// >>> dv/cantxs_mbox_model.sv
// Purpose: behavioural transmit mailbox state machine that pulses status events
// Assumes: the bench holds cmd for one cycle; 1 request, 2 start, 3 ok,
//          4 arbitration lost, 5 error, 6 removed by abort
// Notes:   every completion frees the mailbox, so cancel writes can be refused
`timescale 1ns/1ns
`default_nettype none
module cantxs_mbox_model (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // bench command
  input  wire logic [2:0]             cmd,
  // events to the flag logic
  output cantxs_pkg::cantxs_mbox_ev_s ev
);
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      ev <= '0;
    else
    begin
      ev.new_request <= (cmd == 3'h1);
      ev.start       <= (cmd == 3'h2);
      ev.done        <= (cmd >= 3'h3);
      ev.ok          <= (cmd == 3'h3);
      ev.arb_lost    <= (cmd == 3'h4);
      ev.error       <= (cmd == 3'h5);
      ev.removed     <= (cmd == 3'h6);
      // a finished or aborted message leaves the mailbox free
      ev.pending     <= (cmd == 3'h1) || (ev.pending && cmd < 3'h3);
    end
endmodule : cantxs_mbox_model
`default_nettype wire

// >>> dv/can_tx_mailbox_status_flags_tb.sv
// Purpose: self-checking bench for the transmit mailbox status flags
// Assumes: one wait state per access; read data already stands at the accept edge
// Notes:   mailbox events come from a behavioural model per mailbox
`timescale 1ns/1ns
`default_nettype none
module can_tx_mailbox_status_flags_tb;
  logic                        clk;
  logic                        reset_n;
  logic [3:0]                  addr;
  logic                        rd;
  logic                        wr;
  logic [31:0]                 wdata;
  logic [31:0]                 rdata;
  logic                        wait_req;
  logic                        cancel;
  logic                        irq;
  logic [2:0]                  cmd0;
  logic [2:0]                  cmd1;
  logic [31:0]                 q;
  int                          err_total;
  int                          n_compared;
  cantxs_pkg::cantxs_mbox_ev_s ev0;
  cantxs_pkg::cantxs_mbox_ev_s ev1;

  cantxs_top dut_u (
    .clk(clk), .reset_n(reset_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .mbox0_ev(ev0), .mbox1_ev(ev1),
    .mbox0_cancel_request(cancel), .irq(irq)
  );
  cantxs_mbox_model m0_u (.clk(clk), .reset_n(reset_n), .cmd(cmd0), .ev(ev0));
  cantxs_mbox_model m1_u (.clk(clk), .reset_n(reset_n), .cmd(cmd1), .ev(ev1));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= d;
    @(posedge clk);
    while (wait_req !== 1'b0 && n < 16)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 16)
      chk("waitrequest", 32'h1, 32'h0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic st_chk(input logic [31:0] e);
    bus(1'b0, cantxs_pkg::ADDR_STATUS, 32'h0);
    chk("status", q, e);
  endtask : st_chk

  task automatic st_wr(input logic [31:0] d);
    bus(1'b1, cantxs_pkg::ADDR_STATUS, d);
  endtask : st_wr

  task automatic evt(input int m, input logic [2:0] c);
    @(posedge clk);
    if (m == 0)
      cmd0 <= c;
    else
      cmd1 <= c;
    @(posedge clk);
    cmd0 <= 3'h0;
    cmd1 <= 3'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask : evt

  task automatic t_reset;
    st_chk(32'h0);
    bus(1'b0, cantxs_pkg::ADDR_IRQ_STS, 32'h0);
    chk("irq status", q, 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", q, 32'h0);
    st_wr(32'hFFFF_F070);
    st_chk(32'h0);
    chk("irq pin", {31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_cancel;
    st_wr(32'h80);
    st_chk(32'h0);
    evt(0, 3'h1);
    st_wr(32'h0);
    st_chk(32'h0);
    st_wr(32'h80);
    st_chk(32'h80);
    chk("cancel pin", {31'h0, cancel}, 32'h1);
    evt(0, 3'h6);
    st_chk(32'h1);
    chk("cancel pin", {31'h0, cancel}, 32'h0);
    st_wr(32'h1);
    st_chk(32'h0);
    $display("test cancel done");
  endtask : t_cancel

  task automatic t_mbox(input int m);
    int sh;
    sh = 8 * m;
    evt(m, 3'h1);
    evt(m, 3'h3);
    st_chk(32'h3 << sh);
    st_wr(32'h1 << sh);
    st_chk(32'h0);
    evt(m, 3'h1);
    evt(m, 3'h4);
    st_chk(32'h5 << sh);
    evt(m, 3'h2);
    st_chk(32'h1 << sh);
    evt(m, 3'h5);
    st_chk(32'h9 << sh);
    st_wr(32'h8 << sh);
    st_chk(32'h1 << sh);
    evt(m, 3'h5);
    evt(m, 3'h2);
    st_chk(32'h1 << sh);
    evt(m, 3'h4);
    evt(m, 3'h1);
    st_chk(32'h0);
    evt(m, 3'h3);
    st_wr(32'h2 << sh);
    st_chk(32'h1 << sh);
    st_wr(32'h1 << sh);
    $display("test mailbox %0d done", m);
  endtask : t_mbox

  task automatic t_irq;
    bus(1'b1, cantxs_pkg::ADDR_IRQ_STS, 32'hF);
    bus(1'b1, cantxs_pkg::ADDR_IRQ_MASK, 32'hF);
    evt(1, 3'h5);
    bus(1'b0, cantxs_pkg::ADDR_IRQ_STS, 32'h0);
    chk("irq status", q, 32'hC);
    chk("irq pin", {31'h0, irq}, 32'h1);
    bus(1'b1, cantxs_pkg::ADDR_IRQ_MASK, 32'h3);
    @(posedge clk);
    #1 chk("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, cantxs_pkg::ADDR_IRQ_STS, 32'hC);
    bus(1'b1, cantxs_pkg::ADDR_IRQ_MASK, 32'hF);
    @(posedge clk);
    #1 chk("irq cleared", {31'h0, irq}, 32'h0);
    st_wr(32'h100);
    $display("test irq done");
  endtask : t_irq

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end

  initial
  begin
    err_total  = 0;
    n_compared = 0;
    reset_n    = 1'b0;
    addr       = 4'h0;
    rd         = 1'b0;
    wr         = 1'b0;
    wdata      = 32'h0;
    cmd0       = 3'h0;
    cmd1       = 3'h0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_cancel();
    t_mbox(0);
    t_mbox(1);
    t_irq();
    end_sim();
  end
endmodule : can_tx_mailbox_status_flags_tb
`default_nettype wire
